// ===== include/epi_pkg.sv
// package of constants for the external pin interrupt block
package epi_pkg;
  localparam int EPI_AW = 12;
  localparam int EPI_DW = 32;
  localparam int EPI_NPC = 24;
  localparam logic [11:0] EPI_SENSE_OFS = 12'h000;
  localparam logic [11:0] EPI_MASK_OFS = 12'h004;
  localparam logic [11:0] EPI_FLAGS_OFS = 12'h008;
  localparam logic [11:0] EPI_BANK_EN_OFS = 12'h00C;
  localparam logic [11:0] EPI_BANK_FLAGS_OFS = 12'h010;
  localparam logic [11:0] EPI_PMASK0_OFS = 12'h014;
  localparam logic [11:0] EPI_PMASK1_OFS = 12'h018;
  localparam logic [11:0] EPI_PMASK2_OFS = 12'h01C;
  localparam logic [11:0] EPI_ACK_OFS = 12'h020;
  localparam logic [11:0] EPI_PIN_OFS = 12'h024;
  localparam logic [1:0] EPI_SENSE_LOW = 2'h0;
  localparam logic [1:0] EPI_SENSE_ANY = 2'h1;
  localparam logic [1:0] EPI_SENSE_FALL = 2'h2;
  localparam logic [1:0] EPI_SENSE_RISE = 2'h3;
  localparam int EPI_SENSE_B_LSB = 2;
  localparam int EPI_SENSE_A_LSB = 0;
  localparam logic [7:0] EPI_PMASK1_USED = 8'h7F;
  localparam logic [3:0] EPI_SENSE_RST = 4'h0;
  localparam logic [1:0] EPI_MASK_RST = 2'h0;
  localparam logic [2:0] EPI_BANK_RST = 3'h0;
  localparam logic [7:0] EPI_PMASK_RST = 8'h00;
endpackage

// ===== rtl/epi_top.sv
// external pin and pin-change interrupt controller with apb registers
//
// Contract
// - requests fire even when pins are outputs
// - bank 2 requests on enabled pins 23..16
// - bank 1 requests on enabled pins 14..8
// - bank 0 requests on enabled pins 7..0
// - pin change detected without io clock; code samples the pins on pclk instead
// - sense fields: b in 3:2, a 1:0
// - sense codes: low, any, fall, rise
// - level mode requests while pin low
// - edge modes run on the io clock; code runs them on pclk instead
// - low level detected without a clock; code takes it from the pclk-sampled pin instead
// - low removed before startup gives no interrupt
// - pins sampled before edge detection
// - mask bits and global enable gate requests
// - external flags set on edge, cleared by ack/write1
// - flag reads zero in level mode
// - bank enables and global enable gate bank requests
// - pin mask selects pins per bank
// - bank 2 flag set on change, cleared ack/write1
// - each source has its own request line
// - unused upper register bits read zero
// - bank 1 and 0 flags like bank 2
// - mask bit plus bank enable enables pin
`timescale 1ns/1ns
module epi_top (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [epi_pkg::EPI_AW-1:0] paddr, // apb byte address
  input wire logic [epi_pkg::EPI_DW-1:0] pwdata, // apb write data
  output logic [epi_pkg::EPI_DW-1:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic ext_request_a, // external request pin a
  input wire logic ext_request_b, // external request pin b
  input wire logic [epi_pkg::EPI_NPC-1:0] pin_change_inputs, // pin-change pins
  input wire logic global_irq_enable, // core global interrupt enable
  input wire logic [4:0] handler_ack, // handler entry per vector, pulse
  output logic ext_a_irq, // request a to core
  output logic ext_b_irq, // request b to core
  output logic pin_change_bank0_request, // bank 0 request to core
  output logic pin_change_bank1_request, // bank 1 request to core
  output logic pin_change_bank2_request, // bank 2 request to core
  output logic wake_request // asynchronous-style wake level
);
  import epi_pkg::*;

  ////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [3:0] sense;
    logic [1:0] mask;
    logic [1:0] eflag;
    logic [2:0] bank_en;
    logic [2:0] bflag;
    logic [7:0] pmask0;
    logic [7:0] pmask1;
    logic [7:0] pmask2;
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] ext_s3;
    logic [1:0] ext_last;
    logic [EPI_NPC-1:0] pc_s1;
    logic [EPI_NPC-1:0] pc_s2;
    logic [EPI_NPC-1:0] pc_s3;
    logic [EPI_NPC-1:0] pc_last;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic [4:0] irq;
    logic wake;
  } epi_state_t;

  epi_state_t s_q;
  epi_state_t s_d;

  ////////////////////////////////////////////////////////////////
  // helpers

  logic [1:0] ext_pin;
  logic [1:0] ext_stable;
  logic [EPI_NPC-1:0] pc_stable;
  logic [EPI_NPC-1:0] pc_toggle;
  logic [EPI_NPC-1:0] pc_enabled;
  logic [1:0] ext_hit;
  logic [1:0] ext_level;
  logic [2:0] bank_hit;
  logic wr_en;
  logic rd_en;

  assign ext_pin = {ext_request_b, ext_request_a};
  assign wr_en = psel && penable && pwrite && !s_q.ready;
  assign rd_en = psel && penable && !pwrite && !s_q.ready;

  // pin value counts once second and third stage agree
  assign ext_stable = (s_q.ext_s2 & s_q.ext_s3) | (~(s_q.ext_s2 ^ s_q.ext_s3) & s_q.ext_s2)
                      | ((s_q.ext_s2 ^ s_q.ext_s3) & s_q.ext_last);
  assign pc_stable = (~(s_q.pc_s2 ^ s_q.pc_s3) & s_q.pc_s2)
                     | ((s_q.pc_s2 ^ s_q.pc_s3) & s_q.pc_last);

  assign pc_enabled = {s_q.pmask2 & {8{s_q.bank_en[2]}},
                       s_q.pmask1 & EPI_PMASK1_USED & {8{s_q.bank_en[1]}},
                       s_q.pmask0 & {8{s_q.bank_en[0]}}};
  assign pc_toggle = (pc_stable ^ s_q.pc_last) & pc_enabled;
  assign bank_hit[2] = |pc_toggle[23:16];
  assign bank_hit[1] = |pc_toggle[14:8];
  assign bank_hit[0] = |pc_toggle[7:0];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ext
      logic [1:0] mode;
      assign mode = s_q.sense[2*g +: 2];
      // edge detect on sampled pin value, one driver per bit
      assign ext_hit[g] = (mode == EPI_SENSE_ANY) ? (ext_stable[g] ^ s_q.ext_last[g])
                          : (mode == EPI_SENSE_FALL) ? (!ext_stable[g] && s_q.ext_last[g])
                          : (mode == EPI_SENSE_RISE) ? (ext_stable[g] && !s_q.ext_last[g])
                          : 1'b0;
      // level request follows pin, so a short low gives nothing
      assign ext_level[g] = (mode == EPI_SENSE_LOW) && !ext_stable[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [1:0] level_mode;
    logic [1:0] eclr;
    logic [2:0] bclr;
    level_mode = 2'h0;
    eclr = 2'h0;
    bclr = 3'h0;
    s_d = s_q;
    s_d.ext_s1 = ext_pin;
    s_d.ext_s2 = s_q.ext_s1;
    s_d.ext_s3 = s_q.ext_s2;
    s_d.ext_last = ext_stable;
    s_d.pc_s1 = pin_change_inputs;
    s_d.pc_s2 = s_q.pc_s1;
    s_d.pc_s3 = s_q.pc_s2;
    s_d.pc_last = pc_stable;
    s_d.ready = psel && penable && !s_q.ready;
    s_d.err = 1'b0;
    s_d.rdata = 32'h0000_0000;
    eclr = handler_ack[1:0];
    bclr = handler_ack[4:2];
    if (wr_en) begin
      case (paddr)
        EPI_SENSE_OFS: s_d.sense = pwdata[3:0];
        EPI_MASK_OFS: s_d.mask = pwdata[1:0];
        EPI_FLAGS_OFS: eclr = eclr | pwdata[1:0];
        EPI_BANK_EN_OFS: s_d.bank_en = pwdata[2:0];
        EPI_BANK_FLAGS_OFS: bclr = bclr | pwdata[2:0];
        EPI_PMASK0_OFS: s_d.pmask0 = pwdata[7:0];
        EPI_PMASK1_OFS: s_d.pmask1 = pwdata[7:0] & EPI_PMASK1_USED;
        EPI_PMASK2_OFS: s_d.pmask2 = pwdata[7:0];
        EPI_ACK_OFS: begin
          eclr = eclr | pwdata[1:0];
          bclr = bclr | pwdata[4:2];
        end
        default: s_d.err = 1'b1;
      endcase
    end
    // set wins over clear
    s_d.eflag = (s_q.eflag & ~eclr) | ext_hit;
    s_d.bflag = (s_q.bflag & ~bclr) | bank_hit;
    level_mode[0] = s_q.sense[1:0] == EPI_SENSE_LOW;
    level_mode[1] = s_q.sense[3:2] == EPI_SENSE_LOW;
    s_d.eflag = s_d.eflag & ~level_mode;
    if (rd_en) begin
      case (paddr)
        EPI_SENSE_OFS: s_d.rdata = {28'h0, s_q.sense};
        EPI_MASK_OFS: s_d.rdata = {30'h0, s_q.mask};
        EPI_FLAGS_OFS: s_d.rdata = {30'h0, s_q.eflag};
        EPI_BANK_EN_OFS: s_d.rdata = {29'h0, s_q.bank_en};
        EPI_BANK_FLAGS_OFS: s_d.rdata = {29'h0, s_q.bflag};
        EPI_PMASK0_OFS: s_d.rdata = {24'h0, s_q.pmask0};
        EPI_PMASK1_OFS: s_d.rdata = {24'h0, s_q.pmask1};
        EPI_PMASK2_OFS: s_d.rdata = {24'h0, s_q.pmask2};
        EPI_ACK_OFS: s_d.rdata = 32'h0000_0000;
        EPI_PIN_OFS: s_d.rdata = {6'h0, ext_stable, pc_stable};
        default: s_d.err = 1'b1;
      endcase
    end
    // one line per vector, gated by enables
    s_d.irq[0] = global_irq_enable && s_q.mask[0] && (s_q.eflag[0] || ext_level[0]);
    s_d.irq[1] = global_irq_enable && s_q.mask[1] && (s_q.eflag[1] || ext_level[1]);
    s_d.irq[4:2] = {3{global_irq_enable}} & s_q.bank_en & s_q.bflag;
    s_d.wake = (|(s_q.mask & ext_level)) || (|(s_q.bank_en & s_q.bflag));
  end

  ////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.err;
  assign ext_a_irq = s_q.irq[0];
  assign ext_b_irq = s_q.irq[1];
  assign pin_change_bank0_request = s_q.irq[2];
  assign pin_change_bank1_request = s_q.irq[3];
  assign pin_change_bank2_request = s_q.irq[4];
  assign wake_request = s_q.wake;
endmodule // epi_top

// ===== test/epi_props.sv
// checker for the pin interrupt block
`timescale 1ns/1ns
module epi_props (
  input wire logic pclk, // clk
  input wire logic presetn, // rst
  input wire logic psel, // sel
  input wire logic penable, // en
  input wire logic pwrite, // dir
  input wire logic [epi_pkg::EPI_AW-1:0] paddr, // addr
  input wire logic [epi_pkg::EPI_DW-1:0] prdata, // rdata
  input wire logic pready, // ready
  input wire logic pslverr, // err
  input wire logic global_irq_enable, // gie
  input wire logic ext_a_irq, // irq a
  input wire logic pin_change_bank0_request, // bank 0
  input wire logic pin_change_bank2_request // bank 2
);
  import epi_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire rd = pready && !pwrite;
  AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready too long");
  AST_READY_WAIT: assert property ($rose(penable) && psel |=> pready) else $error("ready late");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == '0) else $error("rdata not idle");
  AST_ERR_READY: assert property (pslverr |-> pready) else $error("err without ready");
  AST_SENSE_TOP: assert property (rd && paddr == EPI_SENSE_OFS |-> prdata[31:4] == '0)
    else $error("sense top bits");
  AST_FLAGS_TOP: assert property (rd && paddr == EPI_FLAGS_OFS |-> prdata[31:2] == '0)
    else $error("flag top bits");
  AST_GATE_A: assert property (ext_a_irq |-> $past(global_irq_enable)) else $error("irq a ungated");
  AST_GATE_BANK: assert property (pin_change_bank0_request || pin_change_bank2_request
    |-> $past(global_irq_enable)) else $error("bank ungated");
  AST_RESET_QUIET: assert property ($rose(presetn) |-> !ext_a_irq && !pready)
    else $error("not quiet after reset");
  cover property (ext_a_irq);
  cover property (pslverr);
  cover property (pin_change_bank2_request);
endmodule // epi_props
bind epi_top epi_props epi_props_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata,
  .pready, .pslverr, .global_irq_enable, .ext_a_irq, .pin_change_bank0_request, .pin_change_bank2_request);

// ===== test/epi_src.sv
// model of the sources driving the request pins
`timescale 1ns/1ns
module epi_src (
  input wire logic [25:0] cmd, // wanted levels
  output logic ext_request_a, // pin a
  output logic ext_request_b, // pin b
  output logic [23:0] pin_change_inputs // change pins
);
  // levels held until the bench moves them
  assign {ext_request_b, ext_request_a, pin_change_inputs} = cmd;
endmodule // epi_src

// ===== test/epi_top_tb_top.sv
// self-checking bench for the pin interrupt block
`timescale 1ns/1ns
module epi_top_tb_top;
  import epi_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, global_irq_enable = 0;
  logic pready, pslverr, ext_request_a, ext_request_b, err, wake;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] irq;
  logic [2:0] bank_req;
  logic [4:0] handler_ack = '0;
  logic [25:0] cmd = 26'h3FFFFFF;
  logic [23:0] pin_change_inputs;
  logic [27:0] rows [8] = '{{EPI_FLAGS_OFS, 8'hFF, 8'h00}, {EPI_BANK_FLAGS_OFS, 8'hFF, 8'h00},
    {EPI_SENSE_OFS, 8'hFF, 8'h0F}, {EPI_MASK_OFS, 8'hFF, 8'h03}, {EPI_BANK_EN_OFS, 8'hFF, 8'h07},
    {EPI_PMASK0_OFS, 8'hA5, 8'hA5}, {EPI_PMASK1_OFS, 8'hFF, 8'h7F}, {EPI_PMASK2_OFS, 8'h5A, 8'h5A}};
  int pk [5] = '{1, 0, 8, 17, 15};
  logic [7:0] pe [5] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h00};
  int miscompares = 0, compares = 0;
  always #2 pclk = ~pclk;
  epi_src epi_src_i (.cmd, .ext_request_a, .ext_request_b, .pin_change_inputs);
  epi_top epi_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_request_a, .ext_request_b, .pin_change_inputs, .global_irq_enable, .handler_ack,
    .ext_a_irq(irq[0]), .ext_b_irq(irq[1]), .pin_change_bank0_request(bank_req[0]),
    .pin_change_bank1_request(bank_req[1]), .pin_change_bank2_request(bank_req[2]), .wake_request(wake));
  ////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, '0);
    chk(rd, {24'h0, e});
  endtask
  // toggle pins, expect flags and request lines, then clear
  task automatic hit(input logic [25:0] m, input logic [11:0] a, input logic [7:0] e, input int sh);
    cmd <= cmd ^ m;
    tick(8);
    rdchk(a, e);
    chk({27'h0, bank_req, irq}, {24'h0, e} << sh);
    apb(1'b1, a, 32'hFF);
    rdchk(a, 8'h00);
  endtask
  task automatic end_sim;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    tick(10);
    presetn <= 1'b1;
    tick(1);
    chk({27'h0, bank_req, irq}, '0);
    for (int i = 0; i < 8; i++) rdchk(rows[i][27:16], 8'h00);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, rows[i][27:16], {24'h0, rows[i][15:8]});
      rdchk(rows[i][27:16], rows[i][7:0]);
    end
    global_irq_enable <= 1'b1;
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, EPI_SENSE_OFS, 32'(c * 5));
      hit(26'h3000000, EPI_FLAGS_OFS, (c != 3) ? 8'h03 : 8'h00, 0);
      hit(26'h3000000, EPI_FLAGS_OFS, (c != 2) ? 8'h03 : 8'h00, 0);
    end
    apb(1'b1, EPI_SENSE_OFS, '0);
    cmd <= cmd ^ 26'h1000000;
    tick(8);
    rdchk(EPI_FLAGS_OFS, 8'h00);
    chk({29'h0, wake, irq}, 32'h5);
    apb(1'b1, EPI_MASK_OFS, 32'h2);
    tick(3);
    chk({30'h0, irq}, '0);
    for (int i = 0; i < 5; i++) hit(26'h1 << pk[i], EPI_BANK_FLAGS_OFS, pe[i], 2);
    global_irq_enable <= 1'b0;
    cmd <= cmd ^ (26'h1 << 17);
    tick(8);
    chk({29'h0, bank_req}, '0);
    rdchk(EPI_BANK_FLAGS_OFS, 8'h04);
    global_irq_enable <= 1'b1;
    tick(2);
    chk({29'h0, bank_req}, 32'h4);
    handler_ack <= 5'h10;
    tick(1);
    handler_ack <= '0;
    tick(3);
    rdchk(EPI_BANK_FLAGS_OFS, 8'h00);
    apb(1'b0, 12'hFFC, '0);
    chk({31'h0, err}, 32'h1);
    // reset again once configured
    presetn <= 1'b0;
    tick(2);
    presetn <= 1'b1;
    tick(2);
    chk({26'h0, wake, bank_req, irq}, '0);
    rdchk(EPI_MASK_OFS, 8'h00);
    rdchk(EPI_BANK_EN_OFS, 8'h00);
    end_sim;
  end
  initial begin
    #40000;
    miscompares++;
    end_sim;
  end
endmodule // epi_top_tb_top
